// *** core/rcp_pkg.sv ***
// Package for the reset-cause and power-mode block.
// Assumes a single 10 MHz system clock and an AXI4-Lite register port.
package rcp_pkg;
  localparam logic [11:0] RCP_ADDR_PWR_GATE = 12'hf80;
  localparam logic [11:0] RCP_ADDR_STATUS = 12'hff0;
  localparam logic [11:0] RCP_ADDR_MODE_CTRL = 12'hf84;
  localparam logic [11:0] RCP_ADDR_MODE_STAT = 12'hf88;
  localparam int RCP_ADDR_W = 12;
  // Status field positions
  localparam int RCP_ST_POR = 7;
  localparam int RCP_ST_STOP = 6;
  localparam int RCP_ST_WDT = 5;
  localparam int RCP_ST_EXT = 4;
  localparam int RCP_ST_LVD = 0;
  // Power gating field positions
  localparam int RCP_PG_AMP = 7;
  localparam int RCP_PG_BO = 4;
  localparam int RCP_PG_TEMP = 3;
  localparam int RCP_PG_ADC = 2;
  localparam int RCP_PG_COMP = 1;
  localparam logic [7:0] RCP_PG_RESET = 8'h80;
  localparam logic [7:0] RCP_PG_WMASK = 8'h9e;
  // Mode control bits
  localparam int RCP_MC_STOP = 0;
  localparam int RCP_MC_HALT = 1;
  localparam logic [1:0] RCP_RESP_OKAY = 2'h0;
  localparam logic [1:0] RCP_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RCP_MODE_ACTIVE = 2'b00,
    RCP_MODE_HALT = 2'b01,
    RCP_MODE_STOP = 2'b10
  } rcp_mode_t;
endpackage

// *** core/rcp_cause_flags.sv ***
// Reset-cause flag store with read-to-clear.
// Assumes event inputs are single-cycle pulses on clk_i.
module rcp_cause_flags
  import rcp_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_b_i, // Synchronous reset, active low
  input wire logic por_i, // Power-on or debugger reset event
  input wire logic ext_i, // External pin reset event
  input wire logic wdt_i, // Watchdog timeout event
  input wire logic in_stop_i, // Device is in stop mode
  input wire logic wake_pin_i, // Stop wake by pin change
  input wire logic rd_clr_i, // Status read completed
  output logic [3:0] flags_o // POR, STOP, WDT, EXTERNAL_PIN_RESET_FLAG
);
  typedef struct packed {
    logic por;
    logic stop;
    logic wdt;
    logic external_pin_reset_flag;
  } rcp_flags_t;

  rcp_flags_t r;
  rcp_flags_t next_r;

  always_comb
  begin
    next_r = r;
    if (rd_clr_i)
    begin
      next_r = '0;
    end
    if (por_i)
    begin
      next_r = '{por: 1'b1, stop: 1'b0, wdt: 1'b0, external_pin_reset_flag: 1'b0};
    end
    else if (ext_i)
    begin
      next_r = '{por: 1'b0, stop: 1'b0, wdt: 1'b0, external_pin_reset_flag: 1'b1};
    end
    else if (wdt_i && in_stop_i)
    begin
      next_r = '{por: 1'b0, stop: 1'b1, wdt: 1'b1, external_pin_reset_flag: 1'b0};
    end
    else if (wdt_i)
    begin
      next_r = '{por: 1'b0, stop: 1'b0, wdt: 1'b1, external_pin_reset_flag: 1'b0};
    end
    else if (wake_pin_i)
    begin
      next_r = '{por: 1'b0, stop: 1'b1, wdt: 1'b0, external_pin_reset_flag: 1'b0};
    end
  end

  // Flags survive the system reset; only events and read-to-clear change them
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i && por_i)
      r <= '{por: 1'b1, stop: 1'b0, wdt: 1'b0, external_pin_reset_flag: 1'b0};
    else
      r <= next_r;
  end

  assign flags_o = {r.por, r.stop, r.wdt, r.external_pin_reset_flag};
endmodule // rcp_cause_flags

// *** core/rcp_mode_ctrl.sv ***
// Stop/halt power-mode sequencer.
// Assumes wake causes are single-cycle pulses on clk_i.
module rcp_mode_ctrl
  import rcp_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_b_i, // Synchronous reset, active low
  input wire logic stop_req_i, // Stop instruction executed
  input wire logic halt_req_i, // Halt instruction executed
  input wire logic irq_i, // Any interrupt pending
  input wire logic wdt_i, // Watchdog timeout
  input wire logic wake_pin_i, // Stop wake by pin change
  input wire logic sys_reset_i, // Power-on, debugger, external pin or brown-out reset event
  output rcp_mode_t mode_o // Current mode
);
  typedef struct packed {
    rcp_mode_t mode;
  } rcp_mc_st_t;

  rcp_mc_st_t r;
  rcp_mc_st_t next_r;

  always_comb
  begin
    next_r = r;
    case (r.mode)
      RCP_MODE_ACTIVE:
      begin
        if (stop_req_i)
          next_r.mode = RCP_MODE_STOP;
        else if (halt_req_i)
          next_r.mode = RCP_MODE_HALT;
      end
      RCP_MODE_HALT:
      begin
        if (irq_i || wdt_i)
          next_r.mode = RCP_MODE_ACTIVE;
      end
      RCP_MODE_STOP:
      begin
        if (wdt_i || wake_pin_i)
          next_r.mode = RCP_MODE_ACTIVE;
      end
      default:
        next_r.mode = RCP_MODE_ACTIVE;
    endcase
    if (sys_reset_i)
      next_r.mode = RCP_MODE_ACTIVE;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      r <= '{mode: RCP_MODE_ACTIVE};
    else
      r <= next_r;
  end

  assign mode_o = r.mode;
endmodule // rcp_mode_ctrl

// *** core/rcp_top.sv ***
// Reset-cause status, power modes and peripheral power gating.
// Assumes an AXI4-Lite master on clk_i and pulse-wide event inputs.
//
// Our own choice: register access over AXI4-Lite.
module rcp_top
  import rcp_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_b_i, // Synchronous system reset, active low
  input wire logic por_i, // Power-on reset event pulse
  input wire logic dbg_rst_i, // Debugger-requested reset pulse
  input wire logic debug_pin_low_i, // Debug pin driven low
  input wire logic ext_rst_i, // External pin reset pulse
  input wire logic wdt_timeout_i, // Watchdog timeout pulse
  input wire logic wake_pin_i, // Enabled port pin changed
  input wire logic bo_reset_i, // Brown-out reset pulse
  input wire logic irq_i, // Interrupt pending
  input wire logic stop_instr_i, // Stop instruction executed
  input wire logic halt_instr_i, // Halt instruction executed
  input wire logic low_voltage_i, // Low-voltage comparator output
  input wire logic brownout_always_on_option_i, // Flash option enabling brown-out
  input wire logic wdt_osc_en_i, // Watchdog oscillator enabled
  input wire logic wdt_en_i, // Watchdog logic enabled
  input wire logic bo_stop_option_i, // Brown-out runs in stop
  input wire logic [3:0] periph_en_i, // Blocks' own enables: temp, adc, comp, bo
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [RCP_ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  output logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  input wire logic [RCP_ADDR_W-1:0] s_axi_araddr, // Read address
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic wdt_ctrl_wr_o, // Pulse: watchdog control write
  output logic [7:0] wdt_ctrl_data_o, // Watchdog control write data
  output logic main_osc_en_o, // Main oscillators running
  output logic sys_clk_en_o, // System clock gate enable
  output logic cpu_run_o, // Processor and PC advance
  output logic xtal_pins_gpio_o, // Crystal pins under port control
  output logic wdt_run_o, // Watchdog oscillator and logic running
  output logic periph_run_o, // Ordinary peripherals not idled
  output logic amp_en_o, // Low-power amplifier enabled
  output logic bo_en_o, // Brown-out detector enabled
  output logic temp_en_o, // Temperature sensor enabled
  output logic adc_en_o, // Converter enabled
  output logic comp_en_o, // Comparator enabled
  output logic [7:0] power_gate_o // Power gating register value
);
  typedef struct packed {
    logic [7:0] pwr_gate;
    logic [RCP_ADDR_W-1:0] waddr;
    logic waddr_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wdata_ok;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic wdt_wr;
    logic [7:0] wdt_data;
  } rcp_top_st_t;

  rcp_top_st_t r;
  rcp_top_st_t next_r;
  logic [3:0] flags;
  rcp_mode_t mode;
  logic rd_clr;
  logic por_evt;
  logic wr_fire;
  logic rd_fire;
  logic stop_req;
  logic halt_req;

  function automatic logic [31:0] rcp_byte(input logic [7:0] v);
    rcp_byte = {24'h000000, v};
  endfunction

  assign por_evt = por_i | dbg_rst_i | (debug_pin_low_i && mode == RCP_MODE_STOP);
  assign stop_req = stop_instr_i && !halt_instr_i;
  assign halt_req = halt_instr_i;

  assign s_axi_awready = !r.waddr_ok && !r.bvalid;
  assign s_axi_wready = !r.wdata_ok && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign wr_fire = r.waddr_ok && r.wdata_ok;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  // Flags clear once the read data has been delivered
  assign rd_clr = r.rvalid && s_axi_rready && r.rdata[RCP_ST_POR+1] == 1'b0
    && r.rresp == RCP_RESP_OKAY && r.rdata[31] == 1'b1;

  always_comb
  begin
    next_r = r;
    next_r.wdt_wr = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_r.waddr = s_axi_awaddr;
      next_r.waddr_ok = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
      next_r.wdata_ok = 1'b1;
    end
    if (wr_fire)
    begin
      next_r.waddr_ok = 1'b0;
      next_r.wdata_ok = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RCP_RESP_OKAY;
      case (r.waddr)
        RCP_ADDR_PWR_GATE:
        begin
          if (r.wstrb[0])
            next_r.pwr_gate = r.wdata[7:0] & RCP_PG_WMASK;
        end
        RCP_ADDR_STATUS:
        begin
          // Writes here go to the watchdog control, not the status
          if (r.wstrb[0])
          begin
            next_r.wdt_wr = 1'b1;
            next_r.wdt_data = r.wdata[7:0];
          end
        end
        RCP_ADDR_MODE_CTRL, RCP_ADDR_MODE_STAT:
          next_r.bresp = RCP_RESP_OKAY;
        default:
          next_r.bresp = RCP_RESP_SLVERR;
      endcase
    end
    if (r.bvalid && s_axi_bready)
      next_r.bvalid = 1'b0;
    if (r.rvalid && s_axi_rready)
      next_r.rvalid = 1'b0;
    if (rd_fire)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RCP_RESP_OKAY;
      case (s_axi_araddr)
        RCP_ADDR_PWR_GATE:
          next_r.rdata = rcp_byte(r.pwr_gate);
        RCP_ADDR_STATUS:
          // Bit 31 marks a status read so its delivery clears the flags
          next_r.rdata = {1'b1, 23'h000000, flags, 3'h0, low_voltage_i};
        RCP_ADDR_MODE_STAT:
          next_r.rdata = rcp_byte({6'h00, mode});
        RCP_ADDR_MODE_CTRL:
          next_r.rdata = '0;
        default:
        begin
          next_r.rdata = '0;
          next_r.rresp = RCP_RESP_SLVERR;
        end
      endcase
    end
    if (por_i)
      next_r.pwr_gate = RCP_PG_RESET;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      r <= '0;
      r.pwr_gate <= por_i ? RCP_PG_RESET : next_r.pwr_gate;
    end
    else
      r <= next_r;
  end

  rcp_cause_flags u_flags (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .por_i(por_evt),
    .ext_i(ext_rst_i),
    .wdt_i(wdt_timeout_i),
    .in_stop_i(mode == RCP_MODE_STOP),
    .wake_pin_i(wake_pin_i && mode == RCP_MODE_STOP),
    .rd_clr_i(rd_clr),
    .flags_o(flags)
  );

  rcp_mode_ctrl u_mode (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .stop_req_i(stop_req),
    .halt_req_i(halt_req),
    .irq_i(irq_i),
    .wdt_i(wdt_timeout_i),
    .wake_pin_i(wake_pin_i),
    .sys_reset_i(por_evt | ext_rst_i | bo_reset_i),
    .mode_o(mode)
  );

  assign main_osc_en_o = mode != RCP_MODE_STOP;
  assign sys_clk_en_o = mode != RCP_MODE_STOP;
  assign cpu_run_o = mode == RCP_MODE_ACTIVE;
  assign xtal_pins_gpio_o = mode == RCP_MODE_STOP;
  assign wdt_run_o = wdt_osc_en_i && wdt_en_i;
  assign periph_run_o = mode != RCP_MODE_STOP;
  assign amp_en_o = !r.pwr_gate[RCP_PG_AMP];
  assign bo_en_o = !r.pwr_gate[RCP_PG_BO] && brownout_always_on_option_i && periph_en_i[0]
    && (mode != RCP_MODE_STOP || bo_stop_option_i);
  assign temp_en_o = !r.pwr_gate[RCP_PG_TEMP] && periph_en_i[3] && periph_run_o;
  assign adc_en_o = !r.pwr_gate[RCP_PG_ADC] && periph_en_i[2] && periph_run_o;
  assign comp_en_o = !r.pwr_gate[RCP_PG_COMP] && periph_en_i[1] && periph_run_o;
  assign power_gate_o = r.pwr_gate;
  assign wdt_ctrl_wr_o = r.wdt_wr;
  assign wdt_ctrl_data_o = r.wdt_data;
endmodule // rcp_top

// *** test/rcp_checker.sv ***
// Checker for the reset-cause and power-mode block.
// Sees only the top module's ports; bound to rcp_top below.
module rcp_checker
  import rcp_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_b_i, // Reset, active low
  input wire logic irq_i, // Interrupt
  input wire logic brownout_always_on_option_i, // Option bit
  input wire logic wdt_osc_en_i, // Watchdog osc
  input wire logic wdt_en_i, // Watchdog logic
  input wire logic main_osc_en_o, // Oscillators
  input wire logic sys_clk_en_o, // Clock gate
  input wire logic cpu_run_o, // Processor runs
  input wire logic xtal_pins_gpio_o, // Crystal pins
  input wire logic wdt_run_o, // Watchdog runs
  input wire logic periph_run_o, // Peripherals
  input wire logic amp_en_o, // Amplifier
  input wire logic bo_en_o, // Brown-out
  input wire logic temp_en_o, // Temp sensor
  input wire logic [7:0] power_gate_o, // Gating
  input wire logic s_axi_rvalid, // Read valid
  input wire logic [31:0] s_axi_rdata // Read data
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_amp_gate: assert property (amp_en_o == !power_gate_o[RCP_PG_AMP])
    else $error("amplifier enable does not follow gating");
  a_temp_gate: assert property (power_gate_o[RCP_PG_TEMP] |-> !temp_en_o)
    else $error("temp sensor enabled while gated");
  a_bo_option: assert property (bo_en_o |-> !power_gate_o[RCP_PG_BO] && brownout_always_on_option_i)
    else $error("brown-out enabled without both enables");
  a_stop_state: assert property (!sys_clk_en_o |-> !main_osc_en_o && !cpu_run_o && xtal_pins_gpio_o && !periph_run_o)
    else $error("stop state outputs wrong");
  a_halt_state: assert property (!cpu_run_o && sys_clk_en_o |-> main_osc_en_o && periph_run_o)
    else $error("halt state outputs wrong");
  a_halt_exit: assert property (!cpu_run_o && sys_clk_en_o && irq_i |-> ##[0:3] cpu_run_o)
    else $error("halt not left on interrupt");
  a_status_rsvd: assert property (s_axi_rvalid && s_axi_rdata[31] |-> s_axi_rdata[3:1] == 3'h0)
    else $error("reserved status bits not zero");
  a_wdt_run: assert property (wdt_run_o == (wdt_osc_en_i && wdt_en_i))
    else $error("watchdog run wrong");
endmodule // rcp_checker

bind rcp_top rcp_checker rcp_checker_i (.*);

// *** test/tb_rcp_top.sv ***
// Self-checking bench for the reset-cause and power-mode block.
// Drives every input itself; AXI4-Lite master tasks on clk_i.
module tb_rcp_top
  import rcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = '0, rst_b_i = '0, low_voltage_i = '0, brownout_always_on_option_i = '0;
  logic wdt_osc_en_i = '0, wdt_en_i = '0, bo_stop_option_i = '0, wseen = '0;
  logic [3:0] periph_en_i = '0, s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wdt_ctrl_wr_o;
  logic main_osc_en_o, sys_clk_en_o, cpu_run_o, xtal_pins_gpio_o, wdt_run_o, periph_run_o;
  logic amp_en_o, bo_en_o, temp_en_o, adc_en_o, comp_en_o;
  logic [7:0] wdt_ctrl_data_o, power_gate_o;
  logic [9:0] evs = 10'h001;
  int error_cnt = 0, compares = 0, seed = 32'h5f5b9fbd;

  rcp_top rcp_top_i (
    .por_i(evs[0]),
    .dbg_rst_i(evs[1]),
    .debug_pin_low_i(evs[2]),
    .ext_rst_i(evs[3]),
    .wdt_timeout_i(evs[4]),
    .wake_pin_i(evs[5]),
    .bo_reset_i(evs[6]),
    .irq_i(evs[7]),
    .stop_instr_i(evs[8]),
    .halt_instr_i(evs[9]),
    .*
  );

  initial
  forever #50 clk_i = ~clk_i;

  always @(posedge clk_i)
    wseen <= wseen | (wdt_ctrl_wr_o === 1'b1);

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic pulse(int i);
    @(posedge clk_i);
    evs[i] <= 1'b1;
    @(posedge clk_i);
    evs[i] <= 1'b0;
  endtask

  task automatic sysrst(logic p);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    evs[0] <= p;
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    evs[0] <= 1'b0;
  endtask

  task automatic axw(logic [11:0] a, logic [31:0] v);
    logic ta, tw, tb;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge clk_i);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clk_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(logic [11:0] a);
    logic ta, tr;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge clk_i);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk_i);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [31:0] st(logic [3:0] f, logic l);
    return {1'b1, 23'h0, f, 3'h0, l};
  endfunction

  // Codes 4 to 6 enter stop before the wake cause
  task automatic cause(int k);
    if (k >= 4)
    begin
      pulse(8);
      @(negedge clk_i);
      chk("stop", {main_osc_en_o, sys_clk_en_o, cpu_run_o, periph_run_o, xtal_pins_gpio_o}, 5'h01);
    end
    pulse(k == 1 ? 3 : (k == 2 || k == 6) ? 4 : k == 3 ? 1 : k == 4 ? 2 : 5);
    sysrst(1'b0);
  endtask

  initial
  begin
    logic [31:0] g;
    int t[10][3] = '{'{1, 0, 1}, '{2, 0, 2}, '{3, 0, 8}, '{4, 0, 8}, '{5, 0, 4},
                     '{6, 0, 6}, '{3, 2, 2}, '{1, 5, 4}, '{6, 2, 2}, '{2, 5, 4}};
    int hx[4] = '{7, 4, 6, 3};
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    evs[0] <= 1'b0;
    axr(RCP_ADDR_PWR_GATE);
    chk("pg_reset", rd, {24'h0, RCP_PG_RESET});
    axr(RCP_ADDR_STATUS);
    chk("st_por", rd, st(4'h8, low_voltage_i));
    axr(RCP_ADDR_STATUS);
    chk("st_clear", rd, st(4'h0, low_voltage_i));
    foreach (t[i])
    begin
      low_voltage_i <= 1'($random(seed));
      cause(t[i][0]);
      if (t[i][1] != 0) cause(t[i][1]);
      axr(RCP_ADDR_STATUS);
      chk("st_flags", rd, st(4'(t[i][2]), low_voltage_i));
    end
    axw(RCP_ADDR_STATUS, 32'h5a);
    @(negedge clk_i);
    chk("wdt_data", {wseen, wdt_ctrl_data_o}, 9'h15a);
    axr(RCP_ADDR_STATUS);
    chk("st_after_wr", rd, st(4'h0, low_voltage_i));
    repeat (8)
    begin
      g = $random(seed);
      {brownout_always_on_option_i, bo_stop_option_i, periph_en_i, wdt_osc_en_i, wdt_en_i} <= 8'($random(seed));
      axw(RCP_ADDR_PWR_GATE, g);
      axr(RCP_ADDR_PWR_GATE);
      chk("pg_rd", rd, g & {24'h0, RCP_PG_WMASK});
      @(negedge clk_i);
      chk("en", {amp_en_o, temp_en_o, adc_en_o, comp_en_o, bo_en_o}, {!g[7], !g[3] & periph_en_i[3],
          !g[2] & periph_en_i[2], !g[1] & periph_en_i[1], !g[4] & periph_en_i[0] & brownout_always_on_option_i});
      chk("pg_out", power_gate_o, g[7:0] & RCP_PG_WMASK);
    end
    sysrst(1'b0);
    axr(RCP_ADDR_PWR_GATE);
    chk("pg_keep", rd, g & {24'h0, RCP_PG_WMASK});
    sysrst(1'b1);
    axr(RCP_ADDR_PWR_GATE);
    chk("pg_por", rd, {24'h0, RCP_PG_RESET});
    axw(RCP_ADDR_PWR_GATE, 32'h0);
    pulse(8);
    @(negedge clk_i);
    chk("amp_stop", {amp_en_o, wdt_run_o}, {1'b1, wdt_osc_en_i & wdt_en_i});
    sysrst(1'b0);
    foreach (hx[i])
    begin
      pulse(9);
      @(negedge clk_i);
      chk("halt", {main_osc_en_o, sys_clk_en_o, cpu_run_o, periph_run_o}, 4'hd);
      pulse(hx[i]);
      repeat (2) @(negedge clk_i);
      chk("halt_exit", cpu_run_o, 1'b1);
    end
    axr(12'h010);
    chk("unmapped", {rs, rd}, {RCP_RESP_SLVERR, 32'h0});
    axw(12'h010, 32'h0);
    chk("wr_unmapped", rs, RCP_RESP_SLVERR);
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    end_of_test();
  end
endmodule // tb_rcp_top
